// file: shared/bchz_pkg.sv
// bus control one: field layout, reset values and decode types
package bchz_pkg;
    localparam int          BCHZ_AW            = 4;
    localparam int          BCHZ_DW            = 32;
    localparam logic [3:0]  BCHZ_OFS_CTRL1     = 4'h0;
    localparam logic [3:0]  BCHZ_OFS_STAT      = 4'h4;
    localparam int          BCHZ_POS_DMA_BURST_PRIORITY    = 16;
    localparam int          BCHZ_POS_ADDR_HIZ  = 15;
    localparam int          BCHZ_POS_MEM_HIZ   = 14;
    localparam int          BCHZ_POS_A0BL      = 11;
    localparam int          BCHZ_POS_A5BL      = 8;
    localparam int          BCHZ_POS_A6BL      = 5;
    localparam int          BCHZ_POS_A0MUX     = 29;
    localparam int          BCHZ_POS_A56CARD   = 0;
    localparam logic        BCHZ_RST_BIT       = 1'b0;
    localparam logic [2:0]  BCHZ_RST_BURST     = 3'h0;
    localparam logic [2:0]  BCHZ_BL_SRAM       = 3'h0;
    localparam logic [2:0]  BCHZ_BL_4          = 3'h1;
    localparam logic [2:0]  BCHZ_BL_8          = 3'h2;
    localparam logic [2:0]  BCHZ_BL_16         = 3'h3;
    localparam logic [2:0]  BCHZ_BL_32         = 3'h4;

    typedef struct packed {
        logic       burst_rom;
        logic [5:0] beats;
    } bchz_area_mode_t;

    typedef struct packed {
        logic req_release;
        logic req_refresh;
        logic req_dma;
        logic req_cpu;
    } bchz_bus_req_t;

    typedef enum logic [2:0] {
        BCHZ_G_NONE    = 3'b000,
        BCHZ_G_RELEASE = 3'b001,
        BCHZ_G_REFRESH = 3'b010,
        BCHZ_G_DMA     = 3'b011,
        BCHZ_G_CPU     = 3'b100
    } bchz_grant_t;
endpackage

// file: logic/bchz_arbiter.sv
// bus arbiter honouring the dma burst priority bit
`timescale 1ns/1ps
`default_nettype none
module bchz_arbiter
    import bchz_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          dma_burst_priority,
    input  wire bchz_bus_req_t req,
    input  wire logic          dma_burst_active,
    output bchz_grant_t        grant
);
    bchz_grant_t grant_ff;
    bchz_grant_t nxt_grant;
    logic        hold_dma;

    assign hold_dma = dma_burst_priority && dma_burst_active && (grant_ff == BCHZ_G_DMA);

    always_comb begin
        nxt_grant = BCHZ_G_NONE;
        if (hold_dma) begin
            nxt_grant = BCHZ_G_DMA;
        end else if (req.req_release) begin
            nxt_grant = BCHZ_G_RELEASE;
        end else if (req.req_refresh) begin
            nxt_grant = BCHZ_G_REFRESH;
        end else if (req.req_dma) begin
            nxt_grant = BCHZ_G_DMA;
        end else if (req.req_cpu) begin
            nxt_grant = BCHZ_G_CPU;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            grant_ff <= BCHZ_G_NONE;
        end else begin
            grant_ff <= nxt_grant;
        end
    end

    assign grant = grant_ff;

    AST_BURST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        hold_dma |=> grant == BCHZ_G_DMA) else $error("dma burst lost bus");
    AST_RELEASE_FIRST: assert property (@(posedge sys_clk) disable iff (rst)
        (req.req_release && !hold_dma) |=> grant == BCHZ_G_RELEASE)
        else $error("release not first");
    AST_REFRESH_OVER_DMA: assert property (@(posedge sys_clk) disable iff (rst)
        (!req.req_release && req.req_refresh && !hold_dma) |=> grant == BCHZ_G_REFRESH)
        else $error("refresh order wrong");
endmodule
`default_nettype wire

// file: logic/bchz_ctrl.sv
// bus control one: burst priority, high-impedance and burst rom fields
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bchz_ctrl
    import bchz_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic [BCHZ_AW-1:0]  reg_addr,
    input  wire logic [BCHZ_DW-1:0]  reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [BCHZ_DW-1:0]  reg_rdata,
    input  wire logic                area0_mode_pin_n,
    input  wire logic                mem_muxed_5_6,
    input  wire logic                sw_standby,
    input  wire bchz_bus_req_t       bus_req,
    input  wire logic                dma_burst_active,
    output bchz_grant_t              bus_grant,
    output logic                     addr_oe,
    output logic                     memctl_oe,
    output bchz_area_mode_t          area0_mode,
    output bchz_area_mode_t          area5_mode,
    output bchz_area_mode_t          area6_mode
);
    // ------------------------------------------------------------
    // decode of a burst field
    // ------------------------------------------------------------
    function automatic bchz_area_mode_t bchz_decode(input logic [2:0] code,
                                                    input logic       muxed);
        bchz_area_mode_t m;
        m = '{burst_rom: 1'b0, beats: 6'h00};
        if (!muxed) begin
            case (code)
                BCHZ_BL_4:  m = '{burst_rom: 1'b1, beats: 6'h04};
                BCHZ_BL_8:  m = '{burst_rom: 1'b1, beats: 6'h08};
                BCHZ_BL_16: m = '{burst_rom: 1'b1, beats: 6'h10};
                BCHZ_BL_32: m = '{burst_rom: 1'b1, beats: 6'h20};
                default:    m = '{burst_rom: 1'b0, beats: 6'h00}; // reserved as sram
            endcase
        end
        return m;
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic       dma_burst_priority_ff;
    logic       addr_hiz_ctrl_ff;
    logic       memctl_hiz_ctrl_ff;
    logic [2:0] area0_burst_len_ff;
    logic [2:0] area5_burst_len_ff;
    logic [2:0] area6_burst_len_ff;
    logic       area56_card_select_ff;
    logic       area0_muxed_flag_ff;
    logic       strap_taken_ff;
    logic [BCHZ_DW-1:0] rdata_ff;
    logic [BCHZ_DW-1:0] nxt_rdata;

    wire wr_ctrl = reg_wr && (reg_addr == BCHZ_OFS_CTRL1);
    wire rd_ctrl = reg_rd && (reg_addr == BCHZ_OFS_CTRL1);
    wire rd_stat = reg_rd && (reg_addr == BCHZ_OFS_STAT);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dma_burst_priority_ff <= BCHZ_RST_BIT;
            addr_hiz_ctrl_ff      <= BCHZ_RST_BIT;
            memctl_hiz_ctrl_ff    <= BCHZ_RST_BIT;
            area0_burst_len_ff    <= BCHZ_RST_BURST;
            area5_burst_len_ff    <= BCHZ_RST_BURST;
            area6_burst_len_ff    <= BCHZ_RST_BURST;
            area56_card_select_ff <= BCHZ_RST_BIT;
        end else if (wr_ctrl) begin
            dma_burst_priority_ff <= reg_wdata[BCHZ_POS_DMA_BURST_PRIORITY];
            addr_hiz_ctrl_ff      <= reg_wdata[BCHZ_POS_ADDR_HIZ];
            memctl_hiz_ctrl_ff    <= reg_wdata[BCHZ_POS_MEM_HIZ];
            area0_burst_len_ff    <= reg_wdata[BCHZ_POS_A0BL +: 3];
            area5_burst_len_ff    <= reg_wdata[BCHZ_POS_A5BL +: 3];
            area6_burst_len_ff    <= reg_wdata[BCHZ_POS_A6BL +: 3];
            area56_card_select_ff <= reg_wdata[BCHZ_POS_A56CARD];
        end
    end

    // strap caught on the first clock after reset release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strap_taken_ff      <= 1'b0;
            area0_muxed_flag_ff <= 1'b0;
        end else if (!strap_taken_ff) begin
            strap_taken_ff      <= 1'b1;
            area0_muxed_flag_ff <= !area0_mode_pin_n;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire [BCHZ_DW-1:0] ctrl_word =
        (BCHZ_DW'(area0_muxed_flag_ff)   << BCHZ_POS_A0MUX)    |
        (BCHZ_DW'(dma_burst_priority_ff) << BCHZ_POS_DMA_BURST_PRIORITY)   |
        (BCHZ_DW'(addr_hiz_ctrl_ff)      << BCHZ_POS_ADDR_HIZ) |
        (BCHZ_DW'(memctl_hiz_ctrl_ff)    << BCHZ_POS_MEM_HIZ)  |
        (BCHZ_DW'(area0_burst_len_ff)    << BCHZ_POS_A0BL)     |
        (BCHZ_DW'(area5_burst_len_ff)    << BCHZ_POS_A5BL)     |
        (BCHZ_DW'(area6_burst_len_ff)    << BCHZ_POS_A6BL)     |
        (BCHZ_DW'(area56_card_select_ff) << BCHZ_POS_A56CARD);
    wire [BCHZ_DW-1:0] stat_word = {29'h0, bus_grant};

    assign nxt_rdata = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : '0);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------
    // area modes
    // ------------------------------------------------------------
    wire area5_muxed = mem_muxed_5_6 && !area56_card_select_ff;
    wire area6_muxed = mem_muxed_5_6 && !area56_card_select_ff;

    assign area0_mode = bchz_decode(area0_burst_len_ff, area0_muxed_flag_ff);
    assign area5_mode = bchz_decode(area5_burst_len_ff, area5_muxed);
    assign area6_mode = bchz_decode(area6_burst_len_ff, area6_muxed);

    // ------------------------------------------------------------
    // arbitration and output enables
    // ------------------------------------------------------------
    bchz_arbiter u_arb (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .dma_burst_priority (dma_burst_priority_ff),
        .req                (bus_req),
        .dma_burst_active   (dma_burst_active),
        .grant              (bus_grant)
    );

    wire released = (bus_grant == BCHZ_G_RELEASE);

    assign addr_oe   = !released && (!sw_standby || addr_hiz_ctrl_ff);
    assign memctl_oe = memctl_hiz_ctrl_ff || (!released && !sw_standby);

    AST_ADDR_FLOAT_RELEASE: assert property (@(posedge sys_clk) disable iff (rst)
        released |-> !addr_oe) else $error("address driven on release");
    AST_ADDR_STANDBY: assert property (@(posedge sys_clk) disable iff (rst)
        (sw_standby && !released) |-> addr_oe == addr_hiz_ctrl_ff)
        else $error("address standby state wrong");
    AST_MEMCTL_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        memctl_hiz_ctrl_ff |-> memctl_oe) else $error("memctl floated");
    AST_MEMCTL_FLOAT: assert property (@(posedge sys_clk) disable iff (rst)
        (!memctl_hiz_ctrl_ff && (sw_standby || released)) |-> !memctl_oe)
        else $error("memctl driven");
    AST_A0_MUX_IGNORE: assert property (@(posedge sys_clk) disable iff (rst)
        area0_muxed_flag_ff |-> !area0_mode.burst_rom) else $error("area0 burst in mux");
    AST_A5_DECODE: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_ctrl && reg_wdata[BCHZ_POS_A5BL +: 3] == 3'h4 && !area5_muxed)
        |=> area5_mode.beats == 6'h20) else $error("area5 decode wrong");
    AST_A6_DECODE: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_ctrl && reg_wdata[BCHZ_POS_A6BL +: 3] == 3'h3 && !area6_muxed)
        |=> area6_mode.beats == 6'h10) else $error("area6 decode wrong");
    AST_A0_DECODE: assert property (@(posedge sys_clk) disable iff (rst)
        (area0_burst_len_ff == 3'h1 && !area0_muxed_flag_ff) |-> area0_mode.beats == 6'h04)
        else $error("area0 decode wrong");
    AST_READ_LATENCY: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ctrl |=> reg_rdata[BCHZ_POS_DMA_BURST_PRIORITY] == $past(dma_burst_priority_ff))
        else $error("read data wrong");

    // ------------------------------------------------------------
    // reset state
    // ------------------------------------------------------------
    AST_RST_PRIO_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        $past(rst) |-> !dma_burst_priority_ff)
        else $error("priority bit set after reset");
    AST_RST_ADDR_HIZ: assert property (@(posedge sys_clk) disable iff (rst)
        $past(rst) |-> !addr_hiz_ctrl_ff)
        else $error("addr hiz bit set after reset");
    AST_RST_MEM_HIZ: assert property (@(posedge sys_clk) disable iff (rst)
        $past(rst) |-> !memctl_hiz_ctrl_ff)
        else $error("memctl hiz bit set after reset");
    AST_RST_A0: assert property (@(posedge sys_clk) disable iff (rst)
        $past(rst) |-> area0_burst_len_ff == BCHZ_RST_BURST)
        else $error("area0 field not cleared");
    AST_RST_A5: assert property (@(posedge sys_clk) disable iff (rst)
        $past(rst) |-> area5_burst_len_ff == BCHZ_RST_BURST)
        else $error("area5 field not cleared");
    AST_RST_A6: assert property (@(posedge sys_clk) disable iff (rst)
        $past(rst) |-> area6_burst_len_ff == BCHZ_RST_BURST)
        else $error("area6 field not cleared");
    AST_RST_RDATA: assert property (@(posedge sys_clk) disable iff (rst)
        $past(rst) |-> reg_rdata == '0)
        else $error("read data not cleared");

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    AST_WR_PRIO: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> dma_burst_priority_ff == $past(reg_wdata[BCHZ_POS_DMA_BURST_PRIORITY]))
        else $error("priority bit not written");
    AST_WR_ADDR_HIZ: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> addr_hiz_ctrl_ff == $past(reg_wdata[BCHZ_POS_ADDR_HIZ]))
        else $error("addr hiz bit not written");
    AST_WR_MEM_HIZ: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> memctl_hiz_ctrl_ff == $past(reg_wdata[BCHZ_POS_MEM_HIZ]))
        else $error("memctl hiz bit not written");
    AST_WR_A0: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> area0_burst_len_ff == $past(reg_wdata[BCHZ_POS_A0BL +: 3]))
        else $error("area0 field not written");
    AST_WR_A5: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> area5_burst_len_ff == $past(reg_wdata[BCHZ_POS_A5BL +: 3]))
        else $error("area5 field not written");
    AST_WR_A6: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> area6_burst_len_ff == $past(reg_wdata[BCHZ_POS_A6BL +: 3]))
        else $error("area6 field not written");
    AST_WR_CARD: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> area56_card_select_ff == $past(reg_wdata[BCHZ_POS_A56CARD]))
        else $error("card select not written");
    AST_HOLD_PRIO: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_ctrl |=> $stable(dma_burst_priority_ff))
        else $error("priority bit changed without write");
    AST_HOLD_FIELDS: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_ctrl |=> $stable(area0_burst_len_ff) && $stable(area5_burst_len_ff)
                     && $stable(area6_burst_len_ff))
        else $error("burst field changed without write");
    AST_STRAP_ONCE: assert property (@(posedge sys_clk) disable iff (rst)
        strap_taken_ff |=> $stable(area0_muxed_flag_ff))
        else $error("muxed flag changed after strap");

    // ------------------------------------------------------------
    // read path, decode, enables and grant hold
    // ------------------------------------------------------------
    AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
        !(rd_ctrl || rd_stat) |=> reg_rdata == '0)
        else $error("read data not idle");
    AST_STAT_READ: assert property (@(posedge sys_clk) disable iff (rst)
        rd_stat |=> reg_rdata[2:0] == $past(bus_grant))
        else $error("status read wrong");
    AST_READ_A0: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ctrl |=> reg_rdata[BCHZ_POS_A0BL +: 3] == $past(area0_burst_len_ff))
        else $error("area0 field read wrong");
    AST_READ_MUX_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ctrl |=> reg_rdata[BCHZ_POS_A0MUX] == $past(area0_muxed_flag_ff))
        else $error("muxed flag read wrong");
    AST_A5_MUX_IGNORE: assert property (@(posedge sys_clk) disable iff (rst)
        area5_muxed |-> !area5_mode.burst_rom)
        else $error("area5 burst in mux");
    AST_A6_MUX_IGNORE: assert property (@(posedge sys_clk) disable iff (rst)
        area6_muxed |-> !area6_mode.burst_rom)
        else $error("area6 burst in mux");
    AST_A0_RESERVED: assert property (@(posedge sys_clk) disable iff (rst)
        (area0_burst_len_ff > BCHZ_BL_32) |-> area0_mode == '0)
        else $error("reserved code not sram");
    AST_A0_SRAM: assert property (@(posedge sys_clk) disable iff (rst)
        (area0_burst_len_ff == BCHZ_BL_SRAM) |-> !area0_mode.burst_rom)
        else $error("area0 sram code gave burst");
    AST_A0_BEATS_32: assert property (@(posedge sys_clk) disable iff (rst)
        (area0_burst_len_ff == BCHZ_BL_32 && !area0_muxed_flag_ff) |-> area0_mode.beats == 6'h20)
        else $error("area0 32 beats wrong");
    AST_A5_BEATS_8: assert property (@(posedge sys_clk) disable iff (rst)
        (area5_burst_len_ff == BCHZ_BL_8 && !area5_muxed) |-> area5_mode.beats == 6'h08)
        else $error("area5 8 beats wrong");
    AST_A6_BEATS_4: assert property (@(posedge sys_clk) disable iff (rst)
        (area6_burst_len_ff == BCHZ_BL_4 && !area6_muxed) |-> area6_mode.beats == 6'h04)
        else $error("area6 4 beats wrong");
    AST_ADDR_NORMAL: assert property (@(posedge sys_clk) disable iff (rst)
        (!sw_standby && !released) |-> addr_oe)
        else $error("address floated in normal run");
    AST_ADDR_DRIVE_STANDBY: assert property (@(posedge sys_clk) disable iff (rst)
        (addr_hiz_ctrl_ff && sw_standby && !released) |-> addr_oe)
        else $error("address floated in standby");
    AST_MEMCTL_NORMAL: assert property (@(posedge sys_clk) disable iff (rst)
        (!sw_standby && !released) |-> memctl_oe)
        else $error("memctl floated in normal run");
    AST_PRIO_GRANT_HELD: assert property (@(posedge sys_clk) disable iff (rst)
        (dma_burst_priority_ff && dma_burst_active && bus_grant == BCHZ_G_DMA)
        |=> bus_grant == BCHZ_G_DMA)
        else $error("priority dma burst lost bus");
endmodule
`default_nettype wire

// file: tb/bchz_far_model.sv
// far side model: external master and dma requesters seen by the arbiter
`timescale 1ns/1ps
`default_nettype none
module bchz_far_model
    import bchz_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [4:0] want,
    output bchz_bus_req_t   bus_req,
    output logic            dma_burst_active
);
    // ------------------------------------------------------------
    // requests held as levels, changed only after a clock edge
    // ------------------------------------------------------------
    // devices assumed 8 bits wide, so every burst length is legal
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_req          <= '0;
            dma_burst_active <= 1'b0;
        end else begin
            bus_req          <= want[3:0];
            dma_burst_active <= want[4] & want[1];
        end
    end
endmodule
`default_nettype wire

// file: tb/bchz_ctrl_tb.sv
// bus control one testbench: fields, decode, high-impedance and grant
`timescale 1ns/1ps
`default_nettype none
module bchz_ctrl_tb
    import bchz_pkg::*;
();
    logic            sys_clk;
    logic            rst;
    logic [3:0]      reg_addr;
    logic [31:0]     reg_wdata;
    logic            reg_wr;
    logic            reg_rd;
    logic [31:0]     reg_rdata;
    logic            area0_mode_pin_n;
    logic            mem_muxed_5_6;
    logic            sw_standby;
    logic [4:0]      want;
    bchz_bus_req_t   bus_req;
    logic            burst;
    bchz_grant_t     bus_grant;
    logic            addr_oe;
    logic            memctl_oe;
    bchz_area_mode_t m0;
    bchz_area_mode_t m5;
    bchz_area_mode_t m6;
    int              fails;
    int              compares;

    always #50 sys_clk = ~sys_clk;

    bchz_far_model i_far (.sys_clk(sys_clk), .rst(rst), .want(want), .bus_req(bus_req),
                          .dma_burst_active(burst));
    bchz_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .area0_mode_pin_n(area0_mode_pin_n), .mem_muxed_5_6(mem_muxed_5_6),
        .sw_standby(sw_standby), .bus_req(bus_req), .dma_burst_active(burst),
        .bus_grant(bus_grant), .addr_oe(addr_oe), .memctl_oe(memctl_oe),
        .area0_mode(m0), .area5_mode(m5), .area6_mode(m6));

    // ------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    task automatic drive(input logic [4:0] w, input logic sb);
        @(posedge sys_clk);
        want       <= w;
        sw_standby <= sb;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic do_reset(input logic p);
        @(posedge sys_clk);
        rst              <= 1'b1;
        area0_mode_pin_n <= p;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    function automatic logic [31:0] mode_of(input logic [2:0] c);
        case (c)
            BCHZ_BL_4:  return 32'h44;
            BCHZ_BL_8:  return 32'h48;
            BCHZ_BL_16: return 32'h50;
            BCHZ_BL_32: return 32'h60;
            default:    return 32'h00;
        endcase
    endfunction

    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        fails++;
        results();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        area0_mode_pin_n = 1'b1;
        mem_muxed_5_6 = 1'b0;
        sw_standby = 1'b0;
        want = 5'h00;
        fails = 0;
        compares = 0;
        do_reset(1'b1);
        rd(BCHZ_OFS_CTRL1, 32'h0);
        chk({30'h0, addr_oe, memctl_oe}, 32'h3);
        wr(BCHZ_OFS_CTRL1, 32'hffff_ffff);
        rd(BCHZ_OFS_CTRL1, 32'h0001_ffe1);
        wr(4'h8, 32'hffff_ffff);
        rd(4'h8, 32'h0);
        wr(BCHZ_OFS_CTRL1, 32'h0000_0001);
        rd(BCHZ_OFS_CTRL1, 32'h0000_0001);
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            wr(BCHZ_OFS_CTRL1, {18'h0, c[2:0], c[2:0], c[2:0], 5'h0});
            chk({25'h0, m0}, mode_of(c[2:0]));
            chk({25'h0, m5}, mode_of(c[2:0]));
            chk({25'h0, m6}, mode_of(c[2:0]));
        end
        @(posedge sys_clk);
        mem_muxed_5_6 <= 1'b1;
        wr(BCHZ_OFS_CTRL1, 32'h0000_0920);
        chk({25'h0, m0}, 32'h44);
        chk({25'h0, m5}, 32'h0);
        chk({25'h0, m6}, 32'h0);
        @(posedge sys_clk);
        mem_muxed_5_6 <= 1'b0;
        do_reset(1'b0);
        rd(BCHZ_OFS_CTRL1, 32'h2000_0000);
        wr(BCHZ_OFS_CTRL1, 32'h0000_0800);
        chk({25'h0, m0}, 32'h0);
        do_reset(1'b1);
        $display("test decode done");
        for (int i = 0; i < 16; i++) begin
            wr(BCHZ_OFS_CTRL1, {16'h0, i[0], i[1], 14'h0});
            drive({1'b0, i[3], 3'h0}, i[2]);
            chk({31'h0, addr_oe}, {31'h0, !i[3] && (!i[2] || i[0])});
            chk({31'h0, memctl_oe}, {31'h0, i[1] || (!i[2] && !i[3])});
        end
        $display("test high impedance done");
        drive(5'h00, 1'b0);
        wr(BCHZ_OFS_CTRL1, 32'h0);
        for (int k = 0; k < 4; k++) begin
            drive({1'b1, 4'hf >> k}, 1'b0);
            chk({29'h0, bus_grant}, 32'(k + 1));
        end
        rd(BCHZ_OFS_STAT, 32'h4);
        wr(BCHZ_OFS_CTRL1, 32'h0001_0000);
        drive(5'h12, 1'b0);
        chk({29'h0, bus_grant}, 32'h3);
        drive(5'h1e, 1'b0);
        chk({29'h0, bus_grant}, 32'h3);
        drive(5'h0e, 1'b0);
        chk({29'h0, bus_grant}, 32'h1);
        $display("test arbiter done");
        results();
    end
endmodule
`default_nettype wire
